// ### hdl/mau_cfg.svh
// Operation
// [R1] Abort moves waiting trigger system to idle.
// [R2] Abort acts only with bus trigger source.
// [R3] Abort keeps all other trigger settings.
// [R4] Trigger while idle after abort: error.
// [R5] Reset command equals an abort.
// [R6] Five math operations, at most one enabled.
// [R7] Math processes each reading or accumulates.
// [R8] Math stays on until off, function change, reset.
// [R9] Validity matrix of operations versus functions.
// [R10] Invalid operation selection turns math off.
// [R11] Valid to invalid change flags settings conflict.
// [R12] Host enables math before writing null/dB.
// [R13] Preset registers plus result registers.
// [R14] Average query returns mean since enable.
// [R15] Average cleared on enable and reset.
// [R16] Five integration times set resolution per range.
// [R17] Four DC current ranges, top unextended.
// [R18] Seven resistance ranges, top unextended.
// [R19] Five AC voltage ranges, default resolution.
// [R20] Two AC current ranges, default resolution.
// [R21] Operation defaults to null; needs state on.
// [R22] Trigger machine: idle, wait; initiate waits.
`ifndef MAU_CFG_SVH
`define MAU_CFG_SVH

`define MAU_A_CMD       8'h00
`define MAU_A_TRIG_SRC  8'h04
`define MAU_A_MEAS_FUNC 8'h08
`define MAU_A_CALC_FUNC 8'h0c
`define MAU_A_CALC_ON   8'h10
`define MAU_A_NPLC      8'h14
`define MAU_A_RANGE     8'h18
`define MAU_A_AC_RES    8'h1c
`define MAU_A_NULL_REF  8'h20
`define MAU_A_DB_REF    8'h24
`define MAU_A_DBM_REF   8'h28
`define MAU_A_LIM_LO    8'h2c
`define MAU_A_LIM_HI    8'h30
`define MAU_A_STATUS    8'h34
`define MAU_A_ERROR     8'h38
`define MAU_A_AVG       8'h3c
`define MAU_A_COUNT     8'h40
`define MAU_A_MAX       8'h44
`define MAU_A_MIN       8'h48
`define MAU_A_RESULT    8'h4c

`define MAU_CMD_INIT    4'h1
`define MAU_CMD_ABORT   4'h2
`define MAU_CMD_BUS_TRG 4'h3
`define MAU_CMD_RST     4'h4
`define MAU_CMD_IF_RST  4'h5

`define MAU_ERR_TRIG_IGN 0
`define MAU_ERR_CONFLICT 1

`define MAU_NUM_OPS      3'h5
`define MAU_NUM_FUNCS    4'h9
`define MAU_NUM_NPLC     3'h5
`define MAU_NUM_SRC      2'h3
`define MAU_AC_RES_DEF   2'h1
`define MAU_AC_RES_MAX   2'h2
`define MAU_DBM_REF_DEF  32'h0000_0258

`define MAU_RANGES_DCV   3'h5
`define MAU_RANGES_DCI   3'h4
`define MAU_RANGES_OHM   3'h7
`define MAU_RANGES_ACV   3'h5
`define MAU_RANGES_ACI   3'h2
`define MAU_RANGES_OTHER 3'h1

`endif

// ### hdl/mau_pkg.sv
package mau_pkg;

    typedef enum logic [0:0] {trig_idle, trig_waiting} mau_trig_e;

    typedef enum logic [1:0] {src_bus, src_ext, src_imm} mau_src_e;

    typedef enum logic [2:0] {op_average, op_db, op_dbm, op_limit, op_null} mau_op_e;

    typedef enum logic [3:0] {
        dc_voltage_function,
        ac_voltage_function,
        dc_current_function,
        ac_current_function,
        res_2w_function,
        res_4w_function,
        frequency_function,
        period_function,
        ratio_function
    } mau_func_e;

    typedef struct packed {
        mau_trig_e          trig;
        mau_src_e           src;
        mau_func_e          func;
        mau_op_e            op;
        logic               calc_on;
        logic [2:0]         nplc;
        logic [2:0]         range;
        logic [1:0]         ac_res;
        logic signed [31:0] null_ref;
        logic signed [31:0] db_ref;
        logic [31:0]        dbm_ref;
        logic signed [31:0] lim_lo;
        logic signed [31:0] lim_hi;
        logic [1:0]         err;
        logic signed [47:0] sum;
        logic [15:0]        count;
        logic signed [31:0] max;
        logic signed [31:0] min;
        logic signed [31:0] result;
        logic               result_valid;
        logic               limit_fail;
        logic               meas_start;
        logic [2:0]         ext_sync;
        logic               ext_level;
        logic [31:0]        rdata;
    } mau_state_s;

endpackage

// ### hdl/mau_core.sv
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "mau_cfg.svh"

module mau_core
    import mau_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // Measurement path
    input  wire logic        ext_trig,
    input  wire logic        reading_valid,
    input  wire logic [31:0] reading,
    output logic             meas_start,
    output logic             waiting_for_trigger,
    output logic             math_active,
    output logic      [31:0] math_result,
    output logic             math_result_valid,
    output logic             limit_fail,
    output logic      [2:0]  resolution_index,
    output logic             top_range_unextended
);

    mau_state_s s;
    mau_state_s next_s;

    // Allowed operation and measurement combinations.
    function automatic logic op_valid(input mau_op_e op, input mau_func_e fn);
        logic v;
        v = 1'b0;
        case (op)
            op_average: v = 1'b1;
            op_limit:   v = 1'b1;
            op_db:      v = (fn == dc_voltage_function) || (fn == ac_voltage_function);
            op_dbm:     v = (fn == dc_voltage_function) || (fn == ac_voltage_function);
            op_null:    v = (fn != ratio_function);
            default:    v = 1'b0;
        endcase
        return v;
    endfunction

    function automatic logic [2:0] range_count(input mau_func_e fn);
        logic [2:0] n;
        n = `MAU_RANGES_OTHER;
        case (fn)
            dc_voltage_function: n = `MAU_RANGES_DCV;
            dc_current_function: n = `MAU_RANGES_DCI;
            res_2w_function:     n = `MAU_RANGES_OHM;
            res_4w_function:     n = `MAU_RANGES_OHM;
            ac_voltage_function: n = `MAU_RANGES_ACV;
            ac_current_function: n = `MAU_RANGES_ACI;
            default:             n = `MAU_RANGES_OTHER;
        endcase
        return n;
    endfunction

    logic               wr_cmd;
    logic [3:0]         cmd;
    logic               ext_edge;
    logic               fire;
    logic               avg_enable;
    logic               active;
    logic signed [31:0] rd_s;
    logic signed [47:0] mean;
    logic [1:0]         err_set;
    logic [2:0]         new_range;
    mau_op_e            new_op;
    mau_func_e          new_func;

    assign active = s.calc_on && op_valid(s.op, s.func);
    assign rd_s   = $signed(reading);
    // The divide is combinational; it only feeds the read mux, so it stays off the reading path.
    assign mean   = (s.count == 16'h0000) ? 48'sh0 : s.sum / $signed({32'h0, s.count});

    always_comb
    begin
        next_s     = s;
        wr_cmd     = wr && (addr == `MAU_A_CMD);
        cmd        = wdata[3:0];
        err_set    = 2'b00;
        avg_enable = 1'b0;
        fire       = 1'b0;
        new_range  = 3'h0;
        new_op     = s.op;
        new_func   = s.func;
        next_s.meas_start   = 1'b0;
        next_s.result_valid = 1'b0;

        // Only the agreeing second and third stages count; the first stage feeds nothing else.
        next_s.ext_sync = {s.ext_sync[1:0], ext_trig};
        ext_edge = 1'b0;
        if (s.ext_sync[2] == s.ext_sync[1])
        begin
            ext_edge         = s.ext_sync[1] && !s.ext_level;
            next_s.ext_level = s.ext_sync[1];
        end

        // Trigger machine.
        case (s.trig)
            trig_idle:
            begin
                if (wr_cmd && cmd == `MAU_CMD_INIT)
                    next_s.trig = trig_waiting; // [R22]
                if (wr_cmd && cmd == `MAU_CMD_BUS_TRG)
                    err_set[`MAU_ERR_TRIG_IGN] = 1'b1; // [R4]
            end
            trig_waiting:
            begin
                case (s.src)
                    src_bus: fire = wr_cmd && (cmd == `MAU_CMD_BUS_TRG);
                    src_ext: fire = ext_edge;
                    src_imm: fire = 1'b1;
                    default: fire = 1'b0;
                endcase
                if (wr_cmd && cmd == `MAU_CMD_ABORT && s.src == src_bus)
                    next_s.trig = trig_idle; // [R1] [R2] [R3]
                else if (fire)
                begin
                    next_s.meas_start = 1'b1;
                    next_s.trig       = trig_idle;
                end
            end
            default: next_s.trig = trig_idle;
        endcase

        if (wr_cmd && cmd == `MAU_CMD_RST)
        begin
            next_s.trig   = trig_idle; // [R5]
            next_s.ac_res = `MAU_AC_RES_DEF; // [R19] [R20]
        end

        if (wr_cmd && cmd == `MAU_CMD_IF_RST)
        begin
            next_s.calc_on = 1'b0; // [R8]
            next_s.sum     = 48'sh0; // [R15]
            next_s.count   = 16'h0000;
            next_s.max     = 32'sh0;
            next_s.min     = 32'sh0;
        end

        if (wr)
        begin
            case (addr)
                `MAU_A_TRIG_SRC:
                    if (wdata[1:0] < `MAU_NUM_SRC)
                        next_s.src = mau_src_e'(wdata[1:0]);
                `MAU_A_MEAS_FUNC:
                    if (wdata[3:0] < `MAU_NUM_FUNCS)
                    begin
                        new_func    = mau_func_e'(wdata[3:0]);
                        next_s.func = new_func;
                        if (new_func != s.func)
                        begin
                            next_s.calc_on = 1'b0; // [R8]
                            next_s.range   = 3'h0;
                        end
                    end
                `MAU_A_CALC_FUNC:
                    if (wdata[2:0] < `MAU_NUM_OPS)
                    begin
                        new_op    = mau_op_e'(wdata[2:0]);
                        next_s.op = new_op; // [R6]
                        if (!op_valid(new_op, s.func))
                        begin
                            next_s.calc_on = 1'b0; // [R10]
                            if (active)
                                err_set[`MAU_ERR_CONFLICT] = 1'b1; // [R11]
                        end
                        else if (s.calc_on && new_op == op_average && s.op != op_average)
                            avg_enable = 1'b1;
                    end
                `MAU_A_CALC_ON:
                begin
                    next_s.calc_on = wdata[0] && op_valid(s.op, s.func); // [R10] [R21]
                    if (wdata[0] && !s.calc_on && s.op == op_average && op_valid(s.op, s.func))
                        avg_enable = 1'b1;
                end
                `MAU_A_NPLC:
                    if (wdata[2:0] < `MAU_NUM_NPLC)
                        next_s.nplc = wdata[2:0]; // [R16]
                `MAU_A_RANGE:
                begin
                    new_range = wdata[2:0];
                    if (new_range < range_count(s.func))
                        next_s.range = new_range; // [R17] [R18] [R19] [R20]
                end
                `MAU_A_AC_RES:
                    if (wdata[1:0] <= `MAU_AC_RES_MAX)
                        next_s.ac_res = wdata[1:0]; // [R19] [R20]
                // The host is expected to switch math on first; the preset is stored either way.
                `MAU_A_NULL_REF: next_s.null_ref = $signed(wdata); // [R12] [R13]
                `MAU_A_DB_REF:   next_s.db_ref   = $signed(wdata); // [R12] [R13]
                `MAU_A_DBM_REF:  next_s.dbm_ref  = wdata; // [R13]
                `MAU_A_LIM_LO:   next_s.lim_lo   = $signed(wdata); // [R13]
                `MAU_A_LIM_HI:   next_s.lim_hi   = $signed(wdata); // [R13]
                `MAU_A_ERROR:    next_s.err      = s.err & ~wdata[1:0];
                default: ;
            endcase
        end

        // Post-measurement math on each reading.
        if (reading_valid)
        begin
            next_s.result_valid = 1'b1;
            next_s.result       = rd_s;
            if (active)
            begin
                case (s.op)
                    op_null: next_s.result = rd_s - s.null_ref; // [R7]
                    op_db:   next_s.result = rd_s - s.db_ref; // [R7]
                    op_dbm:  next_s.result = rd_s; // [R7]
                    op_limit:
                        next_s.limit_fail = (rd_s < s.lim_lo) || (rd_s > s.lim_hi); // [R7]
                    op_average:
                    begin
                        next_s.sum   = s.sum + 48'(rd_s); // [R7] [R14]
                        next_s.count = s.count + 16'h0001;
                        if (s.count == 16'h0000 || rd_s > s.max)
                            next_s.max = rd_s;
                        if (s.count == 16'h0000 || rd_s < s.min)
                            next_s.min = rd_s;
                    end
                    default: ;
                endcase
            end
        end

        if (avg_enable)
        begin
            next_s.sum   = 48'sh0; // [R15]
            next_s.count = 16'h0000;
            next_s.max   = 32'sh0;
            next_s.min   = 32'sh0;
        end

        // Hardware set wins over a same-cycle software clear.
        next_s.err = next_s.err | err_set;

        next_s.rdata = 32'h0;
        if (rd)
        begin
            case (addr)
                `MAU_A_TRIG_SRC:  next_s.rdata = {30'h0, s.src};
                `MAU_A_MEAS_FUNC: next_s.rdata = {28'h0, s.func};
                `MAU_A_CALC_FUNC: next_s.rdata = {29'h0, s.op};
                `MAU_A_CALC_ON:   next_s.rdata = {31'h0, s.calc_on};
                `MAU_A_NPLC:      next_s.rdata = {29'h0, s.nplc};
                `MAU_A_RANGE:     next_s.rdata = {29'h0, s.range};
                `MAU_A_AC_RES:    next_s.rdata = {30'h0, s.ac_res};
                `MAU_A_NULL_REF:  next_s.rdata = s.null_ref;
                `MAU_A_DB_REF:    next_s.rdata = s.db_ref;
                `MAU_A_DBM_REF:   next_s.rdata = s.dbm_ref;
                `MAU_A_LIM_LO:    next_s.rdata = s.lim_lo;
                `MAU_A_LIM_HI:    next_s.rdata = s.lim_hi;
                `MAU_A_STATUS:    next_s.rdata = {29'h0, s.limit_fail, active, s.trig == trig_waiting};
                `MAU_A_ERROR:     next_s.rdata = {30'h0, s.err};
                `MAU_A_AVG:       next_s.rdata = mean[31:0]; // [R14]
                `MAU_A_COUNT:     next_s.rdata = {16'h0, s.count};
                `MAU_A_MAX:       next_s.rdata = s.max;
                `MAU_A_MIN:       next_s.rdata = s.min;
                `MAU_A_RESULT:    next_s.rdata = s.result;
                default:          next_s.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s         <= '0;
            s.trig    <= trig_idle;
            s.src     <= src_imm;
            s.func    <= dc_voltage_function;
            s.op      <= op_null; // [R21]
            s.ac_res  <= `MAU_AC_RES_DEF; // [R19] [R20]
            s.dbm_ref <= `MAU_DBM_REF_DEF;
        end
        else
            s <= next_s;
    end

    // Resolution steps one decade per range and per shorter integration time; AC functions step per AC resolution instead.
    logic [2:0] res_idx;
    logic       top_flag;
    always_comb
    begin
        res_idx  = 3'(s.range + s.nplc); // [R16]
        top_flag = 1'b0;
        if (s.func == ac_voltage_function || s.func == ac_current_function)
            res_idx = 3'(s.range + {1'b0, s.ac_res}); // [R19] [R20]
        if (s.func == dc_current_function || s.func == res_2w_function || s.func == res_4w_function)
            top_flag = (s.range == range_count(s.func) - 3'h1); // [R17] [R18]
    end

    logic [3:0] out_q;
    logic [2:0] res_q;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            out_q <= 4'h0;
            res_q <= 3'h0;
        end
        else
        begin
            out_q <= {next_s.trig == trig_waiting, next_s.calc_on && op_valid(next_s.op, next_s.func),
                      top_flag, 1'b0};
            res_q <= res_idx;
        end
    end

    assign rdata                = s.rdata;
    assign meas_start           = s.meas_start;
    assign waiting_for_trigger  = out_q[3];
    assign math_active          = out_q[2];
    assign top_range_unextended = out_q[1];
    assign resolution_index     = res_q;
    assign math_result          = s.result;
    assign math_result_valid    = s.result_valid;
    assign limit_fail           = s.limit_fail;

endmodule

// ### tb/mau_core_sva.sv
`timescale 1ns/100ps

module mau_core_sva
    import mau_pkg::*;
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Register port
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    // Measurement path
    input wire logic        reading_valid,
    input wire logic [31:0] reading,
    input wire logic        meas_start,
    input wire logic        waiting_for_trigger,
    input wire logic        math_active,
    input wire logic [31:0] math_result,
    input wire logic        math_result_valid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside read cycle");
    a_start_pulse: assert property (meas_start |=> !meas_start)
        else $error("measurement start longer than one cycle");
    // The wait flag is registered beside the state, so it drops in the cycle the start pulse stands.
    a_start_idles: assert property (meas_start |-> !waiting_for_trigger)
        else $error("trigger machine still waiting after start");
    a_wait_cause: assert property ($rose(waiting_for_trigger) |->
        $past(wr) && $past(addr) == 8'h00 && $past(wdata[3:0]) == 4'h1)
        else $error("waiting entered without initiate");
    a_wait_leave: assert property ($fell(waiting_for_trigger) |->
        meas_start || ($past(wr) && $past(addr) == 8'h00))
        else $error("waiting left without trigger or command");
    a_result_follows: assert property (reading_valid |=> math_result_valid)
        else $error("reading not processed");
    a_result_only: assert property (math_result_valid |-> $past(reading_valid))
        else $error("result valid without reading");
    a_result_holds: assert property (!reading_valid |=> $stable(math_result))
        else $error("result changed without reading");
    a_raw_passes: assert property (reading_valid && !math_active |=>
        math_result == $past(reading))
        else $error("inactive math altered reading");
endmodule

bind mau_core mau_core_sva u_sva (.ref_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .reading_valid,
    .reading, .meas_start, .waiting_for_trigger, .math_active, .math_result, .math_result_valid);

// ### tb/mau_meas_model.sv
`timescale 1ns/100ps

module mau_meas_model
    import mau_pkg::*;
#(
    parameter int DELAY = 3
)
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Measurement path
    input  wire logic        meas_start,
    input  wire logic [31:0] value,
    output logic             reading_valid,
    output logic      [31:0] reading
);
    int          cnt;
    logic [31:0] last;

    // Between readings the bus shows the inverse of the last value so stale data cannot pass.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt           <= 0;
            last          <= 32'h0;
            reading       <= 32'h0;
            reading_valid <= 1'b0;
        end
        else
        begin
            reading_valid <= 1'b0;
            reading       <= ~last;
            if (meas_start)
                cnt <= DELAY;
            else if (cnt > 1)
                cnt <= cnt - 1;
            else if (cnt == 1)
            begin
                cnt           <= 0;
                last          <= value;
                reading       <= value;
                reading_valid <= 1'b1;
            end
        end
    end
endmodule

// ### tb/meter_abort_and_math_unit_tb.sv
`timescale 1ns/100ps

module meter_abort_and_math_unit_tb;
    import mau_pkg::*;

    logic        ref_clk, rst, wr, rd, ext_trig, reading_valid, meas_start;
    logic        waiting_for_trigger, math_active, math_result_valid, limit_fail, top;
    logic [7:0]  addr;
    logic [2:0]  res;
    logic [31:0] wdata, rdata, reading, math_result, rv;
    int          num_errors, tests_run, starts;

    mau_core DUT (.ref_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .ext_trig, .reading_valid,
        .reading, .meas_start, .waiting_for_trigger, .math_active, .math_result,
        .math_result_valid, .limit_fail, .resolution_index(res), .top_range_unextended(top));
    mau_meas_model u_meas (.ref_clk, .rst, .meas_start, .value(rv), .reading_valid, .reading);

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (meas_start === 1'b1)
            starts++;

    task automatic results();
        $display("errors %0d compares %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic r(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        chk32($sformatf("reg %h", a), e, rdata);
    endtask
    // Fires an immediate trigger and waits for the processed reading.
    task automatic meas(input logic [31:0] v);
        int i;
        rv = v;
        w(8'h00, 32'h1);
        for (i = 0; i < 20 && math_result_valid !== 1'b1; i++)
            cyc(1);
        if (i == 20)
        begin
            num_errors++;
            $display("MISMATCH result_wait exp 1 got 0");
            results();
        end
    endtask

    task automatic s_reset();
        r(8'h04, 32'h2);
        r(8'h08, 32'h0);
        r(8'h0c, 32'h4);
        r(8'h10, 32'h0);
        r(8'h1c, 32'h1);
        r(8'h28, 32'h0000_0258);
        r(8'h34, 32'h0);
        r(8'h80, 32'h0);
        w(8'h3c, 32'h5);
        r(8'h3c, 32'h0);
    endtask
    task automatic s_abort();
        int n;
        w(8'h04, 32'h0);
        w(8'h00, 32'h1);
        cyc(2);
        chk1("waiting", 1'b1, waiting_for_trigger);
        w(8'h00, 32'h2);
        cyc(2);
        chk1("waiting", 1'b0, waiting_for_trigger);
        n = starts;
        w(8'h00, 32'h3);
        cyc(2);
        chk32("starts", 32'(n), 32'(starts));
        r(8'h38, 32'h1);
        w(8'h38, 32'h1);
        r(8'h38, 32'h0);
        w(8'h00, 32'h1);
        cyc(2);
        chk1("waiting", 1'b1, waiting_for_trigger);
        w(8'h00, 32'h3);
        cyc(3);
        chk32("starts", 32'(n + 1), 32'(starts));
        w(8'h00, 32'h1);
        w(8'h00, 32'h4);
        cyc(2);
        chk1("waiting", 1'b0, waiting_for_trigger);
        r(8'h04, 32'h0);
    endtask
    task automatic s_ext();
        int n;
        w(8'h04, 32'h1);
        w(8'h00, 32'h1);
        w(8'h00, 32'h2);
        cyc(2);
        chk1("waiting", 1'b1, waiting_for_trigger);
        n = starts;
        @(posedge ref_clk);
        ext_trig <= 1'b1;
        cyc(6);
        @(posedge ref_clk);
        ext_trig <= 1'b0;
        cyc(3);
        chk32("starts", 32'(n + 1), 32'(starts));
        w(8'h04, 32'h2);
    endtask
    task automatic s_matrix();
        logic ok;
        for (int f = 0; f < 9; f++)
            for (int o = 0; o < 5; o++)
            begin
                ok = (o == 0 || o == 3) || (o == 4 ? f != 8 : f < 2);
                w(8'h08, 32'(f));
                w(8'h0c, 32'(o));
                w(8'h10, 32'h1);
                cyc(2);
                chk1("math_active", ok, math_active);
            end
    endtask
    task automatic s_math();
        w(8'h38, 32'h3);
        w(8'h08, 32'h2);
        w(8'h0c, 32'h4);
        w(8'h10, 32'h1);
        w(8'h0c, 32'h1);
        cyc(2);
        chk1("math_active", 1'b0, math_active);
        r(8'h38, 32'h2);
        w(8'h08, 32'h0);
        w(8'h0c, 32'h4);
        w(8'h10, 32'h1);
        w(8'h20, 32'h3);
        meas(32'd10);
        chk32("math_result", 32'd7, math_result);
        w(8'h0c, 32'h0);
        meas(32'd4);
        meas(32'd8);
        meas(32'd12);
        r(8'h3c, 32'd8);
        r(8'h40, 32'd3);
        r(8'h44, 32'd12);
        r(8'h48, 32'd4);
        w(8'h10, 32'h0);
        w(8'h10, 32'h1);
        r(8'h40, 32'h0);
        w(8'h00, 32'h5);
        cyc(2);
        chk1("math_active", 1'b0, math_active);
        w(8'h0c, 32'h3);
        w(8'h30, 32'h5);
        w(8'h10, 32'h1);
        meas(32'd9);
        cyc(1);
        chk1("limit_fail", 1'b1, limit_fail);
        meas(32'd2);
        cyc(1);
        chk1("limit_fail", 1'b0, limit_fail);
        r(8'h4c, 32'd2);
        w(8'h08, 32'h1);
        cyc(2);
        chk1("math_active", 1'b0, math_active);
        meas(32'hffff_fffb);
        chk32("math_result", 32'hffff_fffb, math_result);
    endtask
    task automatic s_ranges();
        w(8'h08, 32'h2);
        w(8'h18, 32'h3);
        cyc(3);
        chk1("top", 1'b1, top);
        chk32("resolution", 32'h3, {29'h0, res});
        w(8'h18, 32'h4);
        r(8'h18, 32'h3);
        w(8'h18, 32'h2);
        cyc(3);
        chk1("top", 1'b0, top);
        w(8'h08, 32'h4);
        w(8'h18, 32'h6);
        cyc(3);
        chk1("top", 1'b1, top);
        w(8'h18, 32'h7);
        r(8'h18, 32'h6);
        w(8'h14, 32'h4);
        w(8'h14, 32'h5);
        r(8'h14, 32'h4);
        w(8'h08, 32'h1);
        w(8'h18, 32'h5);
        r(8'h18, 32'h0);
        w(8'h1c, 32'h2);
        r(8'h1c, 32'h2);
        w(8'h00, 32'h4);
        r(8'h1c, 32'h1);
        w(8'h08, 32'h3);
        w(8'h18, 32'h2);
        r(8'h18, 32'h0);
        w(8'h18, 32'h1);
        r(8'h18, 32'h1);
        cyc(3);
        chk32("resolution", 32'h2, {29'h0, res});
    endtask

    initial
    begin
        ref_clk  = 1'b0;
        rst      = 1'b1;
        wr       = 1'b0;
        rd       = 1'b0;
        ext_trig = 1'b0;
        addr     = 8'h00;
        wdata    = 32'h0;
        rv       = 32'h0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        s_reset();
        s_abort();
        s_ext();
        s_matrix();
        s_math();
        s_ranges();
        results();
    end
endmodule
